// ---- lcddc_defs.svh ----
// register offsets, field positions, reset values and decode constants for the control decoder
`ifndef LCDDC_DEFS_SVH
`define LCDDC_DEFS_SVH

`define LCDDC_ADDR_W          6
`define LCDDC_OFS_SCAN        6'h00
`define LCDDC_OFS_PORT        6'h04
`define LCDDC_OFS_CONTRAST    6'h08
`define LCDDC_OFS_MODE        6'h0c
`define LCDDC_OFS_COMMIT      6'h10
`define LCDDC_OFS_STATUS      6'h14
`define LCDDC_OFS_ACT_LEVELS  6'h18
`define LCDDC_OFS_ACT_MODE    6'h1c

`define LCDDC_SCAN_W          6
`define LCDDC_PORT_W          4
`define LCDDC_CODE_W          4
`define LCDDC_MODE_W          4

`define LCDDC_CON_EN_BIT      4
`define LCDDC_MODE_BLANK_BIT  0
`define LCDDC_MODE_SLEEP_BIT  1
`define LCDDC_MODE_DUTY1_BIT  2
`define LCDDC_MODE_DUTY2_BIT  3
`define LCDDC_COMMIT_BIT      0

`define LCDDC_ST_OSC_BIT      0
`define LCDDC_ST_SCAN_BIT     1
`define LCDDC_ST_CODE_REJ_BIT 2
`define LCDDC_ST_DUTY_REJ_BIT 3
`define LCDDC_ST_COMMONS_LSB  4
`define LCDDC_ST_COUNT_LSB    8
`define LCDDC_ACT_PORT_LSB    8
`define LCDDC_ACT_BLANK_BIT   8
`define LCDDC_ACT_SLEEP_BIT   9
`define LCDDC_ACT_DUTY1_BIT   10
`define LCDDC_ACT_DUTY2_BIT   11

`define LCDDC_RST_SCAN        6'h00
`define LCDDC_RST_PORT        4'h0
`define LCDDC_RST_CODE        4'h0
`define LCDDC_RST_MODE        4'h0
`define LCDDC_RST_CNT         8'h00

`define LCDDC_CODE_MAX        4'ha
`define LCDDC_CODE_BASE       4'h2
`define LCDDC_DROP_NONE       4'h0
`define LCDDC_DUTY_8          4'h8
`define LCDDC_DUTY_9          4'h9
`define LCDDC_DUTY_10         4'ha
`define LCDDC_BIAS_DIV        3'h4

`endif

// ---- lcddc_pkg.sv ----
// shared types of the display control decoder
package lcddc_pkg;
    typedef enum logic [1:0] {
        LCDDC_DUTY_EIGHT,
        LCDDC_DUTY_NINE,
        LCDDC_DUTY_TEN,
        LCDDC_DUTY_BAD
    } lcddc_duty_t;

    typedef enum logic {
        LCDDC_BUS_IDLE,
        LCDDC_BUS_ACK
    } lcddc_bus_st_t;
endpackage

// ---- lcddc_scan_pin.sv ----
// one key-scan drive pin: standby level or gated scan pulse
`timescale 1ns/1ps
`default_nettype none
module lcddc_scan_pin (
    input  wire logic level_in,
    input  wire logic scan_active_in,
    input  wire logic scan_pulse_in,
    output logic      drive_out
);
    // a pin whose level bit is low never carries scan pulses
    always_comb begin
        if (scan_active_in) begin
            drive_out = scan_pulse_in & level_in;
        end else begin
            drive_out = level_in;
        end
    end
endmodule
`default_nettype wire

// ---- lcddc_duty_decode.sv ----
// duty select decode: duty kind, active common count, extra common line enables
`include "lcddc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module lcddc_duty_decode
    import lcddc_pkg::*;
(
    input  wire logic        first_in,
    input  wire logic        second_in,
    output lcddc_duty_t      duty_out,
    output logic [3:0]       commons_out,
    output logic             line_nine_en_out,
    output logic             line_ten_en_out
);
    always_comb begin
        case ({second_in, first_in})
            2'h0: begin
                duty_out         = LCDDC_DUTY_EIGHT;
                commons_out      = `LCDDC_DUTY_8;
                line_nine_en_out = 1'b0;
                line_ten_en_out  = 1'b0;
            end
            2'h1: begin
                duty_out         = LCDDC_DUTY_NINE;
                commons_out      = `LCDDC_DUTY_9;
                line_nine_en_out = 1'b1;
                line_ten_en_out  = 1'b0;
            end
            2'h2: begin
                duty_out         = LCDDC_DUTY_TEN;
                commons_out      = `LCDDC_DUTY_10;
                line_nine_en_out = 1'b1;
                line_ten_en_out  = 1'b1;
            end
            default: begin
                duty_out         = LCDDC_DUTY_BAD;
                commons_out      = `LCDDC_DUTY_8;
                line_nine_en_out = 1'b0;
                line_ten_en_out  = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

// ---- lcddc_top.sv ----
// control-data decoder of the segment display driver with avalon-mm register access
`include "lcddc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module lcddc_top
    import lcddc_pkg::*;
(
    input  wire logic                      ref_clk_in,
    input  wire logic                      sys_rst_in,
    input  wire logic                      clk_en_in,
    // avalon-mm slave
    input  wire logic [`LCDDC_ADDR_W-1:0]  avs_address_in,
    input  wire logic                      avs_read_in,
    input  wire logic                      avs_write_in,
    input  wire logic [31:0]               avs_writedata_in,
    input  wire logic [3:0]                avs_byteenable_in,
    output logic [31:0]                    avs_readdata_out,
    output logic                           avs_waitrequest_out,
    // key scan sequencer, same clock
    input  wire logic                      scan_active_in,
    input  wire logic [`LCDDC_SCAN_W-1:0]  scan_pulse_in,
    // pin-level effects
    output logic [`LCDDC_SCAN_W-1:0]       scan_drive_pins_out,
    output logic [`LCDDC_PORT_W-1:0]       general_output_pins_out,
    output logic [`LCDDC_CODE_W-1:0]       top_bias_drop_out,
    output logic                           top_bias_at_supply_out,
    output logic                           segment_blank_out,
    output logic                           sleep_park_out,
    output logic                           oscillator_enable_out,
    output logic [3:0]                     duty_commons_out,
    output logic                           common_line_nine_en_out,
    output logic                           common_line_ten_en_out,
    output logic [2:0]                     bias_divisor_out
);
    // staged copies written by software
    logic [`LCDDC_SCAN_W-1:0]  stg_scan_ff;
    logic [`LCDDC_PORT_W-1:0]  stg_port_ff;
    logic [`LCDDC_CODE_W-1:0]  stg_code_ff;
    logic                      stg_con_en_ff;
    logic [`LCDDC_MODE_W-1:0]  stg_mode_ff;

    // active control group
    logic [`LCDDC_SCAN_W-1:0]  scan_line_level_bits_ff;
    logic [`LCDDC_PORT_W-1:0]  port_level_bits_ff;
    logic [`LCDDC_CODE_W-1:0]  contrast_code_ff;
    logic                      contrast_adjust_enable_ff;
    logic                      segment_blank_bit_ff;
    logic                      sleep_select_bit_ff;
    logic                      duty_select_first_ff;
    logic                      duty_select_second_ff;

    // commit status
    logic                      code_rejected_ff;
    logic                      duty_rejected_ff;
    logic [7:0]                commit_count_ff;

    // bus side
    lcddc_bus_st_t             bus_st_ff;
    lcddc_bus_st_t             nxt_bus_st;
    logic                      wait_ff;
    logic [31:0]               rdata_ff;
    logic [31:0]               nxt_rdata;

    // output flops
    logic [`LCDDC_SCAN_W-1:0]  scan_drive_ff;
    logic [`LCDDC_PORT_W-1:0]  gp_out_ff;
    logic [`LCDDC_CODE_W-1:0]  bias_drop_ff;
    logic                      bias_supply_ff;
    logic                      blank_ff;
    logic                      park_ff;
    logic                      osc_en_ff;
    logic [3:0]                commons_ff;
    logic                      line_nine_ff;
    logic                      line_ten_ff;
    logic [2:0]                bias_div_ff;

    // decode wires
    logic                      req;
    logic                      wr_take;
    logic                      lane0;
    logic                      commit;
    logic                      stg_code_ok;
    logic                      stg_duty_ok;
    logic [`LCDDC_SCAN_W-1:0]  nxt_scan_drive;
    lcddc_duty_t               stg_duty;
    lcddc_duty_t               act_duty;
    logic [3:0]                act_commons;
    logic                      act_nine;
    logic                      act_ten;
    logic [3:0]                stg_commons;
    logic                      stg_nine;
    logic                      stg_ten;

    assign req     = avs_read_in | avs_write_in;
    // a write lands at the edge where the master sees waitrequest low
    assign wr_take = avs_write_in & ~wait_ff;
    assign lane0   = avs_byteenable_in[0];
    assign commit  = wr_take & lane0 & (avs_address_in == `LCDDC_OFS_COMMIT)
                     & avs_writedata_in[`LCDDC_COMMIT_BIT];

    // ---------------- bus handshake ----------------
    always_comb begin
        case (bus_st_ff)
            LCDDC_BUS_IDLE: nxt_bus_st = req ? LCDDC_BUS_ACK : LCDDC_BUS_IDLE;
            LCDDC_BUS_ACK:  nxt_bus_st = LCDDC_BUS_IDLE;
            default:        nxt_bus_st = LCDDC_BUS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            bus_st_ff <= LCDDC_BUS_IDLE;
            wait_ff   <= 1'b1;
        end else if (clk_en_in) begin
            bus_st_ff <= nxt_bus_st;
            // one wait cycle, then a single low cycle that carries the answer
            wait_ff   <= (nxt_bus_st != LCDDC_BUS_ACK);
        end
    end

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        case (avs_address_in)
            `LCDDC_OFS_SCAN:     nxt_rdata[`LCDDC_SCAN_W-1:0] = stg_scan_ff;
            `LCDDC_OFS_PORT:     nxt_rdata[`LCDDC_PORT_W-1:0] = stg_port_ff;
            `LCDDC_OFS_CONTRAST: begin
                nxt_rdata[`LCDDC_CODE_W-1:0]     = stg_code_ff;
                nxt_rdata[`LCDDC_CON_EN_BIT]     = stg_con_en_ff;
            end
            `LCDDC_OFS_MODE:     nxt_rdata[`LCDDC_MODE_W-1:0] = stg_mode_ff;
            `LCDDC_OFS_STATUS: begin
                nxt_rdata[`LCDDC_ST_OSC_BIT]          = osc_en_ff;
                nxt_rdata[`LCDDC_ST_SCAN_BIT]         = scan_active_in;
                nxt_rdata[`LCDDC_ST_CODE_REJ_BIT]     = code_rejected_ff;
                nxt_rdata[`LCDDC_ST_DUTY_REJ_BIT]     = duty_rejected_ff;
                nxt_rdata[`LCDDC_ST_COMMONS_LSB +: 4] = commons_ff;
                nxt_rdata[`LCDDC_ST_COUNT_LSB +: 8]   = commit_count_ff;
            end
            `LCDDC_OFS_ACT_LEVELS: begin
                nxt_rdata[`LCDDC_SCAN_W-1:0]                    = scan_line_level_bits_ff;
                nxt_rdata[`LCDDC_ACT_PORT_LSB +: `LCDDC_PORT_W] = port_level_bits_ff;
            end
            `LCDDC_OFS_ACT_MODE: begin
                nxt_rdata[`LCDDC_CODE_W-1:0]    = contrast_code_ff;
                nxt_rdata[`LCDDC_CON_EN_BIT]    = contrast_adjust_enable_ff;
                nxt_rdata[`LCDDC_ACT_BLANK_BIT] = segment_blank_bit_ff;
                nxt_rdata[`LCDDC_ACT_SLEEP_BIT] = sleep_select_bit_ff;
                nxt_rdata[`LCDDC_ACT_DUTY1_BIT] = duty_select_first_ff;
                nxt_rdata[`LCDDC_ACT_DUTY2_BIT] = duty_select_second_ff;
            end
            default:             nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            rdata_ff <= 32'h0000_0000;
        end else if (clk_en_in) begin
            if (avs_read_in && nxt_bus_st == LCDDC_BUS_ACK) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    // ---------------- staged registers ----------------
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            stg_scan_ff   <= `LCDDC_RST_SCAN;
            stg_port_ff   <= `LCDDC_RST_PORT;
            stg_code_ff   <= `LCDDC_RST_CODE;
            stg_con_en_ff <= 1'b0;
            stg_mode_ff   <= `LCDDC_RST_MODE;
        end else if (clk_en_in && wr_take && lane0) begin
            case (avs_address_in)
                `LCDDC_OFS_SCAN:     stg_scan_ff <= avs_writedata_in[`LCDDC_SCAN_W-1:0];
                `LCDDC_OFS_PORT:     stg_port_ff <= avs_writedata_in[`LCDDC_PORT_W-1:0];
                `LCDDC_OFS_CONTRAST: begin
                    stg_code_ff   <= avs_writedata_in[`LCDDC_CODE_W-1:0];
                    stg_con_en_ff <= avs_writedata_in[`LCDDC_CON_EN_BIT];
                end
                `LCDDC_OFS_MODE:     stg_mode_ff <= avs_writedata_in[`LCDDC_MODE_W-1:0];
                default: begin
                end
            endcase
        end
    end

    lcddc_duty_decode u_stg_duty (
        .first_in         (stg_mode_ff[`LCDDC_MODE_DUTY1_BIT]),
        .second_in        (stg_mode_ff[`LCDDC_MODE_DUTY2_BIT]),
        .duty_out         (stg_duty),
        .commons_out      (stg_commons),
        .line_nine_en_out (stg_nine),
        .line_ten_en_out  (stg_ten)
    );

    // reserved encodings are refused so the active group never holds one
    assign stg_code_ok = (stg_code_ff <= `LCDDC_CODE_MAX);
    assign stg_duty_ok = (stg_duty != LCDDC_DUTY_BAD);

    // ---------------- active group, latched together ----------------
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            scan_line_level_bits_ff   <= `LCDDC_RST_SCAN;
            port_level_bits_ff        <= `LCDDC_RST_PORT;
            contrast_adjust_enable_ff <= 1'b0;
            segment_blank_bit_ff      <= 1'b0;
            sleep_select_bit_ff       <= 1'b0;
        end else if (clk_en_in && commit) begin
            scan_line_level_bits_ff   <= stg_scan_ff;
            port_level_bits_ff        <= stg_port_ff;
            contrast_adjust_enable_ff <= stg_con_en_ff;
            segment_blank_bit_ff      <= stg_mode_ff[`LCDDC_MODE_BLANK_BIT];
            sleep_select_bit_ff       <= stg_mode_ff[`LCDDC_MODE_SLEEP_BIT];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            contrast_code_ff <= `LCDDC_RST_CODE;
            code_rejected_ff <= 1'b0;
        end else if (clk_en_in && commit) begin
            code_rejected_ff <= ~stg_code_ok;
            if (stg_code_ok) begin
                contrast_code_ff <= stg_code_ff;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            duty_select_first_ff  <= 1'b0;
            duty_select_second_ff <= 1'b0;
            duty_rejected_ff      <= 1'b0;
        end else if (clk_en_in && commit) begin
            duty_rejected_ff <= ~stg_duty_ok;
            if (stg_duty_ok) begin
                duty_select_first_ff  <= stg_mode_ff[`LCDDC_MODE_DUTY1_BIT];
                duty_select_second_ff <= stg_mode_ff[`LCDDC_MODE_DUTY2_BIT];
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            commit_count_ff <= `LCDDC_RST_CNT;
        end else if (clk_en_in && commit) begin
            commit_count_ff <= commit_count_ff + 8'h01;
        end
    end

    // ---------------- effects ----------------
    lcddc_duty_decode u_act_duty (
        .first_in         (duty_select_first_ff),
        .second_in        (duty_select_second_ff),
        .duty_out         (act_duty),
        .commons_out      (act_commons),
        .line_nine_en_out (act_nine),
        .line_ten_en_out  (act_ten)
    );

    genvar gi;
    generate
        for (gi = 0; gi < `LCDDC_SCAN_W; gi = gi + 1) begin : g_scan
            lcddc_scan_pin u_pin (
                .level_in       (scan_line_level_bits_ff[gi]),
                .scan_active_in (scan_active_in),
                .scan_pulse_in  (scan_pulse_in[gi]),
                .drive_out      (nxt_scan_drive[gi])
            );
        end
    endgenerate

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            scan_drive_ff <= `LCDDC_RST_SCAN;
        end else if (clk_en_in) begin
            scan_drive_ff <= nxt_scan_drive;
        end
    end

    // ports stay live in sleep; only the display side parks
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            gp_out_ff <= `LCDDC_RST_PORT;
        end else if (clk_en_in) begin
            gp_out_ff <= port_level_bits_ff;
        end
    end

    // drop is counted in 0.03 supply units: code n gives n+2, disabled gives none
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            bias_drop_ff   <= `LCDDC_DROP_NONE;
            bias_supply_ff <= 1'b1;
        end else if (clk_en_in) begin
            bias_supply_ff <= ~contrast_adjust_enable_ff;
            if (contrast_adjust_enable_ff) begin
                bias_drop_ff <= contrast_code_ff + `LCDDC_CODE_BASE;
            end else begin
                bias_drop_ff <= `LCDDC_DROP_NONE;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            blank_ff  <= 1'b0;
            park_ff   <= 1'b0;
            osc_en_ff <= 1'b1;
        end else if (clk_en_in) begin
            // blanking keeps the drive running with off waveforms
            blank_ff  <= segment_blank_bit_ff;
            park_ff   <= sleep_select_bit_ff;
            osc_en_ff <= ~sleep_select_bit_ff | scan_active_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            commons_ff   <= `LCDDC_DUTY_8;
            line_nine_ff <= 1'b0;
            line_ten_ff  <= 1'b0;
            bias_div_ff  <= `LCDDC_BIAS_DIV;
        end else if (clk_en_in) begin
            commons_ff   <= act_commons;
            line_nine_ff <= act_nine;
            line_ten_ff  <= act_ten;
            bias_div_ff  <= `LCDDC_BIAS_DIV;
        end
    end

    assign avs_readdata_out        = rdata_ff;
    assign avs_waitrequest_out     = wait_ff;
    assign scan_drive_pins_out     = scan_drive_ff;
    assign general_output_pins_out = gp_out_ff;
    assign top_bias_drop_out       = bias_drop_ff;
    assign top_bias_at_supply_out  = bias_supply_ff;
    assign segment_blank_out       = blank_ff;
    assign sleep_park_out          = park_ff;
    assign oscillator_enable_out   = osc_en_ff;
    assign duty_commons_out        = commons_ff;
    assign common_line_nine_en_out = line_nine_ff;
    assign common_line_ten_en_out  = line_ten_ff;
    assign bias_divisor_out        = bias_div_ff;
endmodule
`default_nettype wire

// ---- lcddc_scan_seq.sv ----
// behavioural key-scan sequencer feeding scan activity and pulses to the decoder
`timescale 1ns/1ps
`default_nettype none
module lcddc_scan_seq (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       start_in,
    output logic            active_out,
    output logic [5:0]      pulse_out
);
    logic [3:0] cnt_ff;
    logic [3:0] ph_ff;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cnt_ff <= 4'h0;
        end else if (start_in && cnt_ff == 4'h0) begin
            cnt_ff <= 4'hc;
        end else if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        ph_ff <= rst_in ? 4'h0 : ph_ff + 4'h1;
    end

    assign active_out = (cnt_ff != 4'h0);
    // outside a scan the pulse lines toggle, so a decoder that ignores scan_active is caught
    assign pulse_out  = active_out ? (6'h01 << (ph_ff % 4'h6)) : {6{ph_ff[0]}};
endmodule
`default_nettype wire

// ---- lcddc_monitor.sv ----
// concurrent checks on the control decoder top ports
`include "lcddc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module lcddc_monitor (
    input wire logic        ref_clk_in,
    input wire logic        sys_rst_in,
    input wire logic        clk_en_in,
    input wire logic [5:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0]  avs_byteenable_in,
    input wire logic        avs_waitrequest_out,
    input wire logic        scan_active_in,
    input wire logic [5:0]  scan_pulse_in,
    input wire logic [5:0]  scan_drive_pins_out,
    input wire logic [3:0]  general_output_pins_out,
    input wire logic [3:0]  top_bias_drop_out,
    input wire logic        top_bias_at_supply_out,
    input wire logic        segment_blank_out,
    input wire logic        sleep_park_out,
    input wire logic        oscillator_enable_out,
    input wire logic [3:0]  duty_commons_out,
    input wire logic        common_line_nine_en_out,
    input wire logic        common_line_ten_en_out,
    input wire logic [2:0]  bias_divisor_out
);
    wire logic commit_w;
    // a frozen clock enable lands nothing, so commits and answers only count while it is high
    assign commit_w = clk_en_in && avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]
        && avs_address_in == `LCDDC_OFS_COMMIT && avs_writedata_in[`LCDDC_COMMIT_BIT];

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    AST_SCAN_GATED: assert property (scan_active_in && clk_en_in |=>
        (scan_drive_pins_out & ~$past(scan_pulse_in)) == 6'h00) else $error("scan pin without pulse");
    AST_OSC: assert property ($past(clk_en_in) |->
        oscillator_enable_out == (!sleep_park_out || $past(scan_active_in)))
        else $error("oscillator enable wrong");
    AST_BIAS: assert property (bias_divisor_out == 3'h4)
        else $error("bias not quarter");
    AST_DROP: assert property (
        top_bias_at_supply_out ? top_bias_drop_out == 4'h0
        : top_bias_drop_out inside {[4'h2:4'hc]}) else $error("top bias drop out of range");
    AST_DUTY: assert property ({duty_commons_out, common_line_nine_en_out,
        common_line_ten_en_out} inside {6'h20, 6'h26, 6'h2b}) else $error("duty decode wrong");
    AST_WAIT_ONE: assert property (!avs_waitrequest_out && clk_en_in |=> avs_waitrequest_out)
        else $error("waitrequest low too long");
    AST_ANSWER: assert property (clk_en_in && (avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("request not answered");
    AST_HOLD: assert property ($changed({general_output_pins_out, top_bias_drop_out,
        segment_blank_out, sleep_park_out, duty_commons_out}) |-> $past(commit_w, 2))
        else $error("effect changed without commit");
endmodule
bind lcddc_top lcddc_monitor mon (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_waitrequest_out(avs_waitrequest_out),
    .scan_active_in(scan_active_in), .scan_pulse_in(scan_pulse_in),
    .scan_drive_pins_out(scan_drive_pins_out), .general_output_pins_out(general_output_pins_out),
    .top_bias_drop_out(top_bias_drop_out), .top_bias_at_supply_out(top_bias_at_supply_out),
    .segment_blank_out(segment_blank_out), .sleep_park_out(sleep_park_out),
    .oscillator_enable_out(oscillator_enable_out), .duty_commons_out(duty_commons_out),
    .common_line_nine_en_out(common_line_nine_en_out),
    .common_line_ten_en_out(common_line_ten_en_out), .bias_divisor_out(bias_divisor_out));
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the control decoder over its avalon-mm registers
`include "lcddc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk, rst, rd, wr, start, en;
    logic [5:0]  addr;
    logic [31:0] wd, q;
    logic [3:0]  be;
    wire logic [31:0] rdata;
    wire logic        wreq, act, sup, blank, park, osc, n9, n10;
    wire logic [5:0]  pulse, kpins;
    wire logic [3:0]  gp, drop, coms;
    wire logic [2:0]  bdiv;
    int          errors, num_checks, cyc;

    lcddc_top dut (.ref_clk_in(clk), .sys_rst_in(rst), .clk_en_in(en),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
        .scan_active_in(act), .scan_pulse_in(pulse), .scan_drive_pins_out(kpins),
        .general_output_pins_out(gp), .top_bias_drop_out(drop), .top_bias_at_supply_out(sup),
        .segment_blank_out(blank), .sleep_park_out(park), .oscillator_enable_out(osc),
        .duty_commons_out(coms), .common_line_nine_en_out(n9), .common_line_ten_en_out(n10),
        .bias_divisor_out(bdiv));
    lcddc_scan_seq seq (.clk_in(clk), .rst_in(rst), .start_in(start), .active_out(act),
        .pulse_out(pulse));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic end_sim;
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // the run needs a few hundred cycles; this ceiling only catches a stuck handshake
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // request held until waitrequest is sampled low, then released
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a; wd <= d; wr <= w; rd <= !w;
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        q = rdata;
        rd <= 1'b0; wr <= 1'b0;
    endtask

    task automatic commit;
        bus(1'b1, `LCDDC_OFS_COMMIT, 32'h1);
        @(posedge clk);
        @(negedge clk);
    endtask

    initial begin
        rst = 1'b1; rd = 1'b0; wr = 1'b0; start = 1'b0; addr = 6'h00; wd = 32'h0; be = 4'hf;
        en = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({kpins, gp, drop, sup, blank, park, osc}, {6'h00, 4'h0, 4'h0, 4'h9});
        chk({coms, n9, n10, bdiv}, {4'h8, 2'b00, 3'h4});
        bus(1'b1, `LCDDC_OFS_SCAN, 32'h07);
        bus(1'b1, `LCDDC_OFS_PORT, 32'h5);
        bus(1'b0, `LCDDC_OFS_SCAN, 32'h0);
        chk(q, 32'h07);
        @(negedge clk);
        chk({kpins, gp}, 10'h0);
        commit();
        chk({kpins, gp}, {6'h07, 4'h5});
        for (int c = 0; c <= 10; c++) begin
            bus(1'b1, `LCDDC_OFS_CONTRAST, 32'h10 | c);
            commit();
            chk({sup, drop}, c + 2);
        end
        bus(1'b1, `LCDDC_OFS_CONTRAST, 32'h1b);
        commit();
        chk(drop, 32'hc);
        bus(1'b0, `LCDDC_OFS_STATUS, 32'h0);
        chk(q[2], 1'b1);
        bus(1'b1, `LCDDC_OFS_CONTRAST, 32'h05);
        commit();
        chk({sup, drop}, 5'h10);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, `LCDDC_OFS_MODE, i * 4);
            commit();
            chk({coms, n9, n10}, {4'h8 + 4'(i), i > 0, i == 2});
            chk(bdiv, 3'h4);
        end
        bus(1'b1, `LCDDC_OFS_MODE, 32'hc);
        commit();
        chk(coms, 4'ha);
        bus(1'b0, `LCDDC_OFS_STATUS, 32'h0);
        chk(q, 32'h12a9);
        bus(1'b0, `LCDDC_OFS_ACT_MODE, 32'h0);
        chk(q, 32'h805);
        bus(1'b1, `LCDDC_OFS_MODE, 32'h1);
        commit();
        chk({blank, park}, 2'b10);
        bus(1'b1, `LCDDC_OFS_MODE, 32'h2);
        bus(1'b1, `LCDDC_OFS_PORT, 32'ha);
        be <= 4'he;
        bus(1'b1, `LCDDC_OFS_PORT, 32'hf);
        be <= 4'hf;
        commit();
        chk({park, osc, gp}, {2'b10, 4'ha});
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (2) @(posedge clk);
        repeat (8) begin
            @(negedge clk);
            chk(osc, 1'b1);
            chk(kpins & 6'h38, 6'h00);
        end
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk({osc, kpins}, 7'h07);
        // a frozen enable must hold the handshake; the commit lands once after release
        @(posedge clk);
        en <= 1'b0;
        fork
            commit();
            begin
                repeat (3) @(posedge clk);
                chk(wreq, 1'b1);
                en <= 1'b1;
            end
        join
        bus(1'b0, `LCDDC_OFS_STATUS, 32'h0);
        chk(q, 32'h1580);
        bus(1'b0, `LCDDC_OFS_ACT_LEVELS, 32'h0);
        chk(q, 32'ha07);
        bus(1'b0, 6'h3c, 32'h0);
        chk(q, 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire
